// ==== verilog/cpc_dev.sv ====
// Purpose: Coprocessor end: mode word, result registers, multiply and divide.
// Assumes: The CPU end holds a request until ack and drops it right after.
// Notes:   Division is radix four, sixteen steps plus one sign fix-up cycle.
`timescale 1ns/100ps
`default_nettype none
`include "cpc_consts.svh"

module cpc_dev
   import cpc_pkg::*;
(
   input  wire logic   clk_in,
   input  wire logic   reset_n_in,
   cpc_link_if.dev     link,
   output logic [6:0]  mode_out,
   output logic        busy_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Two's complement negate when asked; used for magnitudes and signs.
   function automatic logic [31:0] cond_neg(input logic [31:0] v, input logic en);
      cond_neg = en ? (~v + 32'h0000_0001) : v;
   endfunction

   // Pick the half of a result register named by the output field.
   function automatic logic [15:0] sel_half(input logic [2:0] fld,
                                            input logic [31:0] r0,
                                            input logic [31:0] r1);
      case (fld)
         `CPC_OUT_R0_LO: sel_half = r0[15:0];
         `CPC_OUT_R0_HI: sel_half = r0[31:16];
         `CPC_OUT_R1_LO: sel_half = r1[15:0];
         `CPC_OUT_R1_HI: sel_half = r1[31:16];
         default:        sel_half = `CPC_RSV_DATA;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State.

   localparam cpc_dev_st_t DEV_RST = '{state: CPC_DEV_IDLE,
                                       mode:  `CPC_MODE_RESET,
                                       result_register_zero:  `CPC_RES_RESET,
                                       result_register_one:  `CPC_RES_RESET,
                                       default: '0};

   cpc_dev_st_t st_ff;
   cpc_dev_st_t nxt_st;

   logic [3:0]  op;
   logic [2:0]  out_fld;
   logic        take;
   logic [31:0] divisor;
   logic        sgn_div;

   // Fields of the mode word in effect.
   assign op      = st_ff.mode[`CPC_OP_MSB:`CPC_OP_LSB];
   assign out_fld = st_ff.mode[`CPC_OUT_MSB:`CPC_OUT_LSB];

   // A request seen during the ack cycle is the old one still held, so skip it.
   assign take    = link.req && !st_ff.ack && (st_ff.state == CPC_DEV_IDLE);

   // The two operands of one compute transfer form the 32-bit divisor.
   assign divisor = {link.op_a, link.op_b};
   assign sgn_div = (op == `CPC_OP_DIVS);

   ////////////////////////////////////////////////////////////////////////////
   // Next state.

   // Products, divider trial subtractions and the transfer decode.
   always_comb begin
      logic [31:0] prod_u;
      logic [31:0] prod_s;
      logic [34:0] sh;
      logic [34:0] d1;
      logic [34:0] d2;
      logic [34:0] d3;
      logic [1:0]  qd;
      logic [31:0] q_fix;
      logic [31:0] r_fix;
      prod_u = 32'h0000_0000;
      prod_s = 32'h0000_0000;
      sh     = 35'h0;
      d1     = 35'h0;
      d2     = 35'h0;
      d3     = 35'h0;
      qd     = 2'h0;
      q_fix  = 32'h0000_0000;
      r_fix  = 32'h0000_0000;
      nxt_st = st_ff;
      nxt_st.ack = 1'b0;

      // Both products are formed every cycle; the mode only picks one.
      prod_u = {16'h0000, link.op_a} * {16'h0000, link.op_b};
      prod_s = 32'($signed(link.op_a) * $signed(link.op_b));

      // Radix-four step: try three, two and one times the divisor in turn.
      sh = {st_ff.part[32:0], st_ff.dvd[31:30]};
      d1 = {3'h0, st_ff.dvs};
      d2 = {2'h0, st_ff.dvs, 1'b0};
      d3 = d1 + d2;

      case (st_ff.state)
         CPC_DEV_IDLE: begin
            if (take) begin
               case (link.kind)
                  // A mode write stores the word and answers with the half the new output field picks.
                  CPC_KIND_MODE: begin
                     nxt_st.mode  = link.op_b[6:0];
                     nxt_st.ack   = 1'b1;
                     nxt_st.rdata = sel_half(link.op_b[6:4], st_ff.result_register_zero, st_ff.result_register_one);
                  end
                  // Load: only the 32-bit load mode writes result zero.
                  CPC_KIND_LOAD: begin
                     if (op == `CPC_OP_LOAD32) begin
                        nxt_st.result_register_zero = {link.op_a, link.op_b};
                     end
                     nxt_st.ack   = 1'b1;
                     nxt_st.rdata = sel_half(out_fld, st_ff.result_register_zero, st_ff.result_register_one);
                  end
                  // Compute: multiply finishes now, divide starts its steps.
                  CPC_KIND_CALC: begin
                     case (op)
                        `CPC_OP_MULU, `CPC_OP_MULS: begin
                           nxt_st.result_register_zero  = (op == `CPC_OP_MULS) ? prod_s : prod_u;
                           nxt_st.ack   = 1'b1;
                           nxt_st.rdata = sel_half(out_fld, nxt_st.result_register_zero, st_ff.result_register_one);
                           nxt_st.flags = `CPC_FLAGS_DONE;
                        end
                        `CPC_OP_DIVU, `CPC_OP_DIVS: begin
                           // Signed division works on magnitudes and fixes signs after.
                           nxt_st.dvd   = cond_neg(st_ff.result_register_zero, sgn_div && st_ff.result_register_zero[31]);
                           nxt_st.dvs   = cond_neg(divisor, sgn_div && divisor[31]);
                           nxt_st.neg_q = sgn_div && (st_ff.result_register_zero[31] ^ divisor[31]);
                           nxt_st.neg_r = sgn_div && st_ff.result_register_zero[31];
                           nxt_st.part  = 35'h0;
                           nxt_st.quo   = 32'h0000_0000;
                           nxt_st.cnt   = 5'h00;
                           nxt_st.state = CPC_DEV_DIV;
                        end
                        // Read mode and reserved codes leave both registers alone.
                        default: begin
                           nxt_st.ack   = 1'b1;
                           nxt_st.rdata = sel_half(out_fld, st_ff.result_register_zero, st_ff.result_register_one);
                           nxt_st.flags = `CPC_FLAGS_DONE;
                        end
                     endcase
                  end
                  default: begin
                     nxt_st.ack   = 1'b1;
                     nxt_st.rdata = `CPC_RSV_DATA;
                  end
               endcase
            end
         end
         // One quotient digit per cycle; the request is stalled meanwhile.
         CPC_DEV_DIV: begin
            if (sh >= d3) begin
               nxt_st.part = sh - d3;
               qd = 2'h3;
            end else if (sh >= d2) begin
               nxt_st.part = sh - d2;
               qd = 2'h2;
            end else if (sh >= d1) begin
               nxt_st.part = sh - d1;
               qd = 2'h1;
            end else begin
               nxt_st.part = sh;
               qd = 2'h0;
            end
            nxt_st.quo = {st_ff.quo[29:0], qd};
            nxt_st.dvd = {st_ff.dvd[29:0], 2'h0};
            nxt_st.cnt = st_ff.cnt + 5'h01;
            if (st_ff.cnt == (`CPC_DIV_STEPS - 5'h01)) begin
               nxt_st.state = CPC_DEV_FIX;
            end
         end
         // Restore signs, store both results and answer the held request.
         CPC_DEV_FIX: begin
            q_fix = cond_neg(st_ff.quo, st_ff.neg_q);
            r_fix = cond_neg(st_ff.part[31:0], st_ff.neg_r);
            nxt_st.result_register_zero  = q_fix;
            nxt_st.result_register_one  = r_fix;
            nxt_st.rdata = sel_half(out_fld, q_fix, r_fix);
            nxt_st.flags = `CPC_FLAGS_DONE;
            nxt_st.ack   = 1'b1;
            nxt_st.state = CPC_DEV_IDLE;
         end
         default: begin
            nxt_st.state = CPC_DEV_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   // Results hold between operations since only the paths above write them.
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         st_ff <= DEV_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   // Divide by zero gives all-ones quotient, or one for a signed negative dividend; zero over zero is the CPU's to avoid.
   assign link.ack   = st_ff.ack;
   assign link.rdata = st_ff.rdata;
   assign link.flags = st_ff.flags;
   assign mode_out   = st_ff.mode;
   assign busy_out   = (st_ff.state != CPC_DEV_IDLE);

endmodule
`default_nettype wire

// ==== verilog/cpc_consts.svh ====
// Purpose: Shared constants of the coprocessor multiply/divide datapath.
// Assumes: Both link ends and the package include this file by its bare name.
// Notes:   Definitions only; the guard keeps double inclusion harmless.
//
// Function
// - Mode codes 4/5 multiply into result zero.
// - Mode write, then compute transfer with operands.
// - Multiply returns all four flags zero.
// - Product held until a later operation.
// - Extended short immediate replaces second operand.
// - Divide is 32 by 32, quotient and remainder.
// - CPU loads dividend in mode 0x02 first.
// - Mode 0x02 load puts operands in result zero.
// - Codes 8/9 divide, quotient zero, remainder one.
// - Output field picks one of four result halves.
// - Read modes return halves without computing.
// - Divide returns all four flags zero.
// - CPU never divides zero by zero.
// - Quotient and remainder held until overwritten.
// - CPU sends divisor in one compute transfer.
// - Seven-bit mode word, output and operation fields.
// - Multiply one cycle, divide 17 cycles, stall.
`ifndef CPC_CONSTS_SVH
`define CPC_CONSTS_SVH

`define CPC_DATA_W      16
`define CPC_MODE_W      7
`define CPC_OP_LSB      0
`define CPC_OP_MSB      3
`define CPC_OUT_LSB     4
`define CPC_OUT_MSB     6

`define CPC_OP_LOAD32   4'h2
`define CPC_OP_READ     4'h3
`define CPC_OP_MULU     4'h4
`define CPC_OP_MULS     4'h5
`define CPC_OP_DIVU     4'h8
`define CPC_OP_DIVS     4'h9

`define CPC_OUT_R0_LO   3'h0
`define CPC_OUT_R0_HI   3'h1
`define CPC_OUT_R1_LO   3'h2
`define CPC_OUT_R1_HI   3'h3

`define CPC_MODE_RESET  7'h03
`define CPC_RES_RESET   32'h0000_0000
`define CPC_FLAGS_DONE  4'h0
`define CPC_RSV_DATA    16'h0000
`define CPC_DIV_STEPS   5'h10
`define CPC_IMM_PAD     9'h000

`endif

// ==== verilog/cpc_pkg.sv ====
// Purpose: Types shared by the coprocessor link and both of its ends.
// Assumes: Constants come from the shared header.
// Notes:   Each end keeps all of its state in one packed struct.
`default_nettype none
`include "cpc_consts.svh"

package cpc_pkg;

   // Kind of transfer carried on the link.
   typedef enum logic [1:0] {CPC_KIND_MODE, CPC_KIND_LOAD, CPC_KIND_CALC} cpc_kind_t;

   typedef enum logic [1:0] {CPC_DEV_IDLE, CPC_DEV_DIV, CPC_DEV_FIX} cpc_dev_state_t;

   typedef enum logic {CPC_CPU_IDLE, CPC_CPU_WAIT} cpc_cpu_state_t;

   // Device state; part is wide enough for four times a remainder plus three.
   typedef struct packed {
      cpc_dev_state_t state;
      logic [6:0]     mode;
      logic [31:0]    result_register_zero;
      logic [31:0]    result_register_one;
      logic [31:0]    dvd;
      logic [31:0]    dvs;
      logic [31:0]    quo;
      logic [34:0]    part;
      logic [4:0]     cnt;
      logic           neg_q;
      logic           neg_r;
      logic           ack;
      logic [15:0]    rdata;
      logic [3:0]     flags;
   } cpc_dev_st_t;

   typedef struct packed {
      cpc_cpu_state_t state;
      logic           req;
      cpc_kind_t      kind;
      logic [15:0]    op_a;
      logic [15:0]    op_b;
      logic           done;
      logic [15:0]    data;
      logic [3:0]     flags;
   } cpc_cpu_st_t;

endpackage
`default_nettype wire

// ==== verilog/cpc_link_if.sv ====
// Purpose: Transfer link between the CPU end and the coprocessor end.
// Assumes: Both ends run on the same clock.
// Notes:   The request stays up until the answer pulse is seen.
`timescale 1ns/100ps
`default_nettype none

interface cpc_link_if;
   import cpc_pkg::*;

   logic        req;     // Transfer request, held until ack.
   cpc_kind_t   kind;    // Mode write, load or compute transfer.
   logic [15:0] op_a;    // First operand.
   logic [15:0] op_b;    // Second operand or extended immediate.
   logic        ack;     // One-cycle answer pulse.
   logic [15:0] rdata;   // Selected result half.
   logic [3:0]  flags;   // Carry, overflow, zero, negative.

   modport dev (
      input  req,
      input  kind,
      input  op_a,
      input  op_b,
      output ack,
      output rdata,
      output flags
   );

   modport cpu (
      output req,
      output kind,
      output op_a,
      output op_b,
      input  ack,
      input  rdata,
      input  flags
   );

endinterface
`default_nettype wire

// ==== verilog/cpc_cpu.sv ====
// Purpose: CPU end: turns user commands into link transfers and waits for ack.
// Assumes: The coprocessor end answers every request with one ack pulse.
// Notes:   One transfer is in flight at a time; ready drops while waiting.
`timescale 1ns/100ps
`default_nettype none
`include "cpc_consts.svh"

module cpc_cpu
   import cpc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   input  wire logic        cmd_valid_in,
   input  wire cpc_kind_t   cmd_kind_in,
   input  wire logic [15:0] cmd_a_in,
   input  wire logic [15:0] cmd_b_in,
   input  wire logic        cmd_use_imm_in,
   input  wire logic [6:0]  cmd_short_immediate_in,
   input  wire logic        cmd_ext_valid_in,
   input  wire logic [8:0]  cmd_ext9_in,
   output logic             cmd_ready_out,
   output logic             done_out,
   output logic [15:0]      done_data_out,
   output logic [3:0]       done_flags_out,
   cpc_link_if.cpu          link
);

   localparam cpc_cpu_st_t CPU_RST = '{state: CPC_CPU_IDLE,
                                       kind:  CPC_KIND_MODE,
                                       default: '0};

   cpc_cpu_st_t st_ff;
   cpc_cpu_st_t nxt_st;

   ////////////////////////////////////////////////////////////////////////////
   // Next state.

   // Issue on an accepted command, retire on the ack pulse.
   always_comb begin
      logic [15:0] imm;
      imm    = {`CPC_IMM_PAD, cmd_short_immediate_in};
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      // A prefix supplies the upper nine bits; otherwise they are zero.
      if (cmd_ext_valid_in) begin
         imm = {cmd_ext9_in, cmd_short_immediate_in};
      end
      case (st_ff.state)
         CPC_CPU_IDLE: begin
            if (cmd_valid_in) begin
               nxt_st.req   = 1'b1;
               nxt_st.kind  = cmd_kind_in;
               nxt_st.op_a  = cmd_a_in;
               nxt_st.op_b  = cmd_use_imm_in ? imm : cmd_b_in;
               nxt_st.state = CPC_CPU_WAIT;
            end
         end
         // The request stays up through a divide stall until the answer.
         CPC_CPU_WAIT: begin
            if (link.ack) begin
               nxt_st.req   = 1'b0;
               nxt_st.done  = 1'b1;
               nxt_st.data  = link.rdata;
               nxt_st.flags = link.flags;
               nxt_st.state = CPC_CPU_IDLE;
            end
         end
         default: begin
            nxt_st.state = CPC_CPU_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   // Ordering of mode, load and divisor is the user's job.
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         st_ff <= CPU_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   // Ready is combinational so a command can be offered in the idle cycle.
   assign cmd_ready_out  = (st_ff.state == CPC_CPU_IDLE);
   assign done_out       = st_ff.done;
   assign done_data_out  = st_ff.data;
   assign done_flags_out = st_ff.flags;
   assign link.req       = st_ff.req;
   assign link.kind      = st_ff.kind;
   assign link.op_a      = st_ff.op_a;
   assign link.op_b      = st_ff.op_b;

endmodule
`default_nettype wire

// ==== tb/cpc_link_asserts.sv ====
// Purpose: Timing and value checks on the link between the two ends.
// Assumes: One clock; reset is synchronous and active low.
// Notes:   The mode word is tracked from acked mode writes.
`timescale 1ns/100ps
`default_nettype none
`include "cpc_consts.svh"

module cpc_link_asserts
   import cpc_pkg::*;
(
   input wire logic        clk_in,
   input wire logic        reset_n_in,
   input wire logic        req,
   input wire cpc_kind_t   kind,
   input wire logic [15:0] op_a,
   input wire logic [15:0] op_b,
   input wire logic        ack,
   input wire logic [15:0] rdata,
   input wire logic [3:0]  flags
);
   logic [6:0]  mode_ff;
   logic [6:0]  nxt_mode;
   logic [31:0] prod;
   logic [15:0] prod_half;
   logic        is_mul;
   logic        is_div;

   ////////////////////////////////////////////////////////////
   // Mode copy updates on the ack edge, a cycle after the device, which is safe
   // because the next request cannot be taken earlier than that.
   always_comb begin
      nxt_mode = mode_ff;
      if (!reset_n_in) begin
         nxt_mode = `CPC_MODE_RESET;
      end else if (ack && req && kind == CPC_KIND_MODE) begin
         nxt_mode = op_b[6:0];
      end
      if (mode_ff[0]) begin
         prod = $signed({{16{op_a[15]}}, op_a}) * $signed({{16{op_b[15]}}, op_b});
      end else begin
         prod = {16'h0000, op_a} * {16'h0000, op_b};
      end
      prod_half = mode_ff[4] ? prod[31:16] : prod[15:0];
   end

   always_ff @(posedge clk_in) begin
      mode_ff <= nxt_mode;
   end

   // Operation decode of the current transfer.
   assign is_mul = kind == CPC_KIND_CALC && mode_ff[6:5] == 2'b00 &&
                   (mode_ff[3:0] == `CPC_OP_MULU || mode_ff[3:0] == `CPC_OP_MULS);
   assign is_div = kind == CPC_KIND_CALC &&
                   (mode_ff[3:0] == `CPC_OP_DIVU || mode_ff[3:0] == `CPC_OP_DIVS);

   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   flags_zero_a: assert property (ack |-> flags == `CPC_FLAGS_DONE)
      else $error("flags not zero on answer");
   mul_result_a: assert property ($rose(req) && is_mul |=> ack && rdata == $past(prod_half))
      else $error("product half wrong or late");
   div_latency_a: assert property ($rose(req) && is_div |=>
      (!ack)[*8] ##1 (!ack)[*8] ##1 !ack ##1 ack) else $error("divide answer timing wrong");
   short_answer_a: assert property ($rose(req) && !is_div |=> ack)
      else $error("single cycle answer missing");
   ack_pulse_a: assert property (ack |=> !ack)
      else $error("answer longer than one cycle");
   ack_cause_a: assert property ($rose(ack) |-> $past(req, 1) && req)
      else $error("answer without request");
   req_hold_a: assert property (req && !ack |=> req && $stable(kind) && $stable(op_a) &&
      $stable(op_b)) else $error("request changed before answer");
   req_drop_a: assert property (ack |=> !req)
      else $error("request not dropped after answer");
   rdata_hold_a: assert property (!ack |-> $stable(rdata) && $stable(flags))
      else $error("result changed without answer");
endmodule
`default_nettype wire

// ==== tb/mul_div_coprocessor_datapath_test.sv ====
// Purpose: Drives the CPU end against the coprocessor end and scores results.
// Assumes: Commands are accepted while ready is high.
// Notes:   A register model predicts every done value in command order.
`timescale 1ns/100ps
`default_nettype none
`include "cpc_consts.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
   $display("BAD %0t: got %h expected %h", $time, (got), (exp)); end end

module mul_div_coprocessor_datapath_test;
   import cpc_pkg::*;
   logic        clk_in, reset_n_in, cmd_valid, cmd_imm, cmd_ext_v, cmd_ready, done, busy;
   cpc_kind_t   cmd_kind;
   logic [15:0] cmd_a, cmd_b, done_data;
   logic [6:0]  cmd_short_immediate, mode_seen, md;
   logic [8:0]  cmd_ext9;
   logic [3:0]  done_flags;
   logic [31:0] r0, r1, dvd, dvs, seed;
   logic [31:0] cycles = 32'h0000_0000;
   logic [24:0] mon_e;
   logic [24:0] exp_q[$];    // Mode after the command, divide flag, care bit, half.
   logic [4:0]  busy_n = 5'h00;
   int          n_errors = 0;
   int          comparisons = 0;

   ////////////////////////////////////////////////////////////
   cpc_link_if link ();
   cpc_cpu u_cpc_cpu (.clk_in(clk_in), .reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid),
      .cmd_kind_in(cmd_kind), .cmd_a_in(cmd_a), .cmd_b_in(cmd_b), .cmd_use_imm_in(cmd_imm),
      .cmd_short_immediate_in(cmd_short_immediate), .cmd_ext_valid_in(cmd_ext_v), .cmd_ext9_in(cmd_ext9),
      .cmd_ready_out(cmd_ready), .done_out(done), .done_data_out(done_data),
      .done_flags_out(done_flags), .link(link));
   cpc_dev u_cpc_dev (.clk_in(clk_in), .reset_n_in(reset_n_in), .link(link),
      .mode_out(mode_seen), .busy_out(busy));
   cpc_link_asserts u_cpc_link_asserts (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .req(link.req), .kind(link.kind), .op_a(link.op_a), .op_b(link.op_b), .ack(link.ack),
      .rdata(link.rdata), .flags(link.flags));

   // Result half picked by the output field; fields 4 to 7 read as zero.
   function automatic logic [15:0] pick(input logic [2:0] f);
      case (f)
         3'h0: pick = r0[15:0];
         3'h1: pick = r0[31:16];
         3'h2: pick = r1[15:0];
         3'h3: pick = r1[31:16];
         default: pick = 16'h0000;
      endcase
   endfunction

   // Predicts the answer, notes it, then hands the command over one edge.
   task automatic send(input cpc_kind_t k, input logic [15:0] a, input logic [15:0] b,
                       input logic imm);
      logic        care;
      logic [15:0] e;
      logic        dv;
      care = 1'b1;
      if (k == CPC_KIND_MODE) md = b[6:0];
      e = pick(md[6:4]);
      if (k == CPC_KIND_LOAD && md[3:0] == `CPC_OP_LOAD32) r0 = {a, b};
      if (k == CPC_KIND_CALC) begin
         case (md[3:0])
            `CPC_OP_MULU: r0 = {16'h0000, a} * {16'h0000, b};
            `CPC_OP_MULS: r0 = $signed({{16{a[15]}}, a}) * $signed({{16{b[15]}}, b});
            `CPC_OP_DIVU: begin
               r1 = r0 % {a, b};
               r0 = r0 / {a, b};
            end
            `CPC_OP_DIVS: begin
               r1 = $signed(r0) % $signed({a, b});
               r0 = $signed(r0) / $signed({a, b});
            end
            `CPC_OP_READ: ;
            default: care = 1'b0;
         endcase
         e = pick(md[6:4]);
      end
      dv = (k == CPC_KIND_CALC) && (md[3:0] == `CPC_OP_DIVU || md[3:0] == `CPC_OP_DIVS);
      exp_q.push_back({md, dv, care, e});
      @(negedge clk_in);
      for (int i = 0; i < 40 && cmd_ready !== 1'b1; i++) @(negedge clk_in);
      @(posedge clk_in);
      cmd_valid <= 1'b1;
      cmd_kind <= k;
      cmd_a <= a;
      cmd_imm <= imm;
      cmd_b <= imm ? ~b : b;
      cmd_short_immediate <= b[6:0];
      cmd_ext9 <= b[15:7];
      cmd_ext_v <= imm && (b[15:7] != 9'h000 || $urandom_range(1) != 0);
      @(posedge clk_in);
      cmd_valid <= 1'b0;
   endtask

   // Reads all four result halves through the read mode.
   task automatic read_all();
      for (int f = 0; f < 4; f++) begin
         send(CPC_KIND_MODE, 16'h0000, {9'h000, 1'b0, f[1:0], 4'h3}, f[0]);
         send(CPC_KIND_CALC, 16'h0000, 16'h0000, 1'b0);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   // Scoreboard: every done pulse takes the oldest prediction.
   // Busy cycles are counted between answers, so a stall that is too short shows up.
   always @(posedge clk_in) begin
      if (done === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("BAD %0t: unexpected done", $time);
         end else begin
            mon_e = exp_q.pop_front();
            if (mon_e[16]) `CHK(done_data, mon_e[15:0])
            `CHK(done_flags, 4'h0)
            `CHK(mode_seen, mon_e[24:18])
            `CHK(busy_n, mon_e[17] ? `CPC_DIV_STEPS + 5'h01 : 5'h00)
         end
         busy_n <= 5'h00;
      end else if (busy === 1'b1) begin
         busy_n <= busy_n + 5'h01;
      end
   end

   // Hang guard; the whole run needs well under two thousand cycles.
   always @(posedge clk_in) begin
      cycles <= cycles + 32'h0000_0001;
      if (cycles == 32'h0000_1388) begin
         n_errors++;
         end_of_test();
      end
   end

   // Multiplies and divides, each followed by read-back; reserved codes, then one final read-back.
   initial begin
      seed = $urandom(66);
      reset_n_in = 1'b0;
      {cmd_valid, cmd_imm, cmd_ext_v, cmd_a, cmd_b, cmd_short_immediate, cmd_ext9} = '0;
      cmd_kind = CPC_KIND_MODE;
      r0 = 32'h0000_0000;
      r1 = 32'h0000_0000;
      md = `CPC_MODE_RESET;
      repeat (6) @(posedge clk_in);
      reset_n_in <= 1'b1;
      @(negedge clk_in);
      `CHK(mode_seen, `CPC_MODE_RESET)
      read_all();
      for (int n = 0; n < 16; n++) begin
         send(CPC_KIND_MODE, 16'h0000, {9'h000, 2'b00, n[0], 3'b010, n[1]}, n[2]);
         send(CPC_KIND_CALC, 16'($urandom), 16'($urandom), n[2]);
         send(CPC_KIND_MODE, 16'h0000, 16'h0013, n[3]);
         send(CPC_KIND_CALC, 16'h0000, 16'h0000, 1'b0);
      end
      for (int n = 0; n < 16; n++) begin
         dvd = $urandom;
         dvs = ($urandom | 32'h0000_0001) & 32'hffff_fffd;
         send(CPC_KIND_MODE, 16'h0000, 16'h0002, 1'b0);
         send(CPC_KIND_LOAD, dvd[31:16], dvd[15:0], n[3]);
         send(CPC_KIND_MODE, 16'h0000, {9'h000, 1'b0, n[1:0], 3'b100, n[2]}, 1'b0);
         send(CPC_KIND_CALC, dvs[31:16], dvs[15:0], n[3]);
         read_all();
      end
      for (int n = 0; n < 5; n++) begin
         send(CPC_KIND_MODE, 16'h0000, {9'h000, 1'b1, n[1:0], 4'(11 + n)}, 1'b0);
         send(CPC_KIND_CALC, 16'($urandom), 16'($urandom), 1'b0);
         send(CPC_KIND_LOAD, 16'($urandom), 16'($urandom), 1'b0);
      end
      read_all();
      for (int i = 0; i < 100 && exp_q.size() != 0; i++) @(posedge clk_in);
      repeat (3) @(posedge clk_in);
      // A command that was never answered leaves its note behind and fails the run.
      `CHK(exp_q.size(), 0)
      end_of_test();
   end
endmodule
`default_nettype wire
